// file: core/gldc_pkg.sv
/*
 * Shared constants and types of the guard-lock diagnostic controller:
 * register map, field positions, reset values, flash codes, timing figures.
 * Assumes a 125 MHz system clock and an AXI4-Lite register bus.
 */
package gldc_pkg;

  // ---------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------
  localparam longint unsigned CLK_HZ = 125_000_000;
  localparam longint unsigned WARN_MIN = 30;
  localparam longint unsigned WARN_CYCLES = WARN_MIN * 60 * CLK_HZ;
  localparam longint unsigned YEL_HZ = 3;
  localparam longint unsigned YEL_HALF_CYCLES = CLK_HZ / (2 * YEL_HZ);
  localparam longint unsigned SLOT_MS = 200;
  localparam longint unsigned SLOT_CYCLES = CLK_HZ / 1000 * SLOT_MS;
  localparam logic [4:0] PAUSE_SLOTS = 5'h04;
  localparam int WARN_CNT_W = 40;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam int CTRL_LAMP_BIT = 0;
  localparam int STS_STATE_LSB = 0;
  localparam int STS_CODE_LSB = 4;
  localparam int STS_SAFE_BIT = 8;
  localparam int STS_LOCK_BIT = 9;
  localparam int STS_DIAG_BIT = 10;
  localparam int STS_OPEN_BIT = 11;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------
  // Flash codes
  // ---------------------------------------------------------------
  localparam logic [2:0] CODE_NONE = 3'h0;
  localparam logic [2:0] CODE_OUT_A = 3'h1;
  localparam logic [2:0] CODE_OUT_B = 3'h2;
  localparam logic [2:0] CODE_CROSS = 3'h3;
  localparam logic [2:0] CODE_TEMP = 3'h4;
  localparam logic [2:0] CODE_ACT = 3'h5;
  localparam logic [2:0] CODE_COMB = 3'h6;
  localparam logic [2:0] CODE_INTERNAL = 3'h7;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RUN = 3'b001,
    ST_WARN = 3'b010,
    ST_FAIL = 3'b100
  } gldc_state_e;

  typedef struct packed {
    logic ready;
    logic guard_closed;
    logic act_detect;
    logic act_near;
    logic lock_target;
    logic lock_cond;
    logic flt_out_a;
    logic flt_out_b;
    logic flt_cross;
    logic flt_temp;
    logic err_act;
    logic err_comb;
    logic err_internal;
  } gldc_pins_s;

  localparam int PIN_W = $bits(gldc_pins_s);

  typedef struct packed {
    logic safe_out_a;
    logic safe_out_b;
    logic lock_path_out;
    logic lock_path_out_n;
    logic diag_out;
    logic led_green;
    logic led_yellow;
    logic led_red;
  } gldc_outs_s;

  typedef struct packed {
    logic [PIN_W-1:0] sync1;
    logic [PIN_W-1:0] sync2;
    logic [PIN_W-1:0] sync3;
    logic [PIN_W-1:0] filt;
    gldc_state_e state;
    logic [2:0] code;
    logic seen_open;
    logic [WARN_CNT_W-1:0] warn_cnt;
    logic [31:0] slot_cnt;
    logic [4:0] pos;
    logic [31:0] yel_cnt;
    logic yel_ph;
    gldc_outs_s outs;
    logic [31:0] ctrl;
    logic aw_got;
    logic [7:0] awaddr;
    logic w_got;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } gldc_regs_s;

endpackage

// file: core/gldc_top.sv
/*
 * Guard-lock diagnostic controller: enabling paths, diagnostic output,
 * LED flash codes, warning timer and failure latch, plus an AXI4-Lite
 * register slave. Pin inputs are asynchronous; the AXI master shares aclk.
 */
`timescale 1ns/1ps

module gldc_top #(
  parameter longint unsigned WARN_CYC = gldc_pkg::WARN_CYCLES,
  parameter longint unsigned SLOT_CYC = gldc_pkg::SLOT_CYCLES,
  parameter longint unsigned YEL_HALF = gldc_pkg::YEL_HALF_CYCLES
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Sensor and fault pins
  input wire gldc_pkg::gldc_pins_s pins,
  // Outputs and indicators
  output gldc_pkg::gldc_outs_s outs,
  // AXI4-Lite write
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);

  // Refuse timing figures that the counters cannot hold
  if (WARN_CYC < 2 || WARN_CYC >= (64'h1 << gldc_pkg::WARN_CNT_W) ||
      SLOT_CYC < 1 || SLOT_CYC > 64'hffff_ffff ||
      YEL_HALF < 1 || YEL_HALF > 64'hffff_ffff) begin : g_bad_timing
    $error("gldc_top: timing parameter out of range");
  end

  localparam logic [gldc_pkg::WARN_CNT_W-1:0] WARN_LAST =
    gldc_pkg::WARN_CNT_W'(WARN_CYC - 1);
  localparam logic [31:0] SLOT_LAST = 32'(SLOT_CYC - 1);
  localparam logic [31:0] YEL_LAST = 32'(YEL_HALF - 1);

  gldc_pkg::gldc_regs_s st_ff;
  gldc_pkg::gldc_regs_s nxt_st;
  gldc_pkg::gldc_pins_s p;
  logic locked;
  logic [2:0] imm_code;
  logic [2:0] warn_code;
  logic red_flash;
  logic [4:0] group_len;

  // ---------------------------------------------------------------
  // Decoded pin conditions
  // ---------------------------------------------------------------
  always_comb begin
    p = gldc_pkg::gldc_pins_s'(st_ff.filt);
    locked = p.act_detect & p.lock_target & p.lock_cond;
    if (p.err_internal) begin
      imm_code = gldc_pkg::CODE_INTERNAL;
    end else if (p.err_comb) begin
      imm_code = gldc_pkg::CODE_COMB;
    end else if (p.err_act) begin
      imm_code = gldc_pkg::CODE_ACT;
    end else begin
      imm_code = gldc_pkg::CODE_NONE;
    end
    if (p.flt_cross || (p.flt_out_a && p.flt_out_b)) begin
      warn_code = gldc_pkg::CODE_CROSS;
    end else if (p.flt_temp) begin
      warn_code = gldc_pkg::CODE_TEMP;
    end else if (p.flt_out_a) begin
      warn_code = gldc_pkg::CODE_OUT_A;
    end else if (p.flt_out_b) begin
      warn_code = gldc_pkg::CODE_OUT_B;
    end else begin
      warn_code = gldc_pkg::CODE_NONE;
    end
    group_len = {1'b0, st_ff.code, 1'b0} + gldc_pkg::PAUSE_SLOTS;
    red_flash = (st_ff.pos < {1'b0, st_ff.code, 1'b0}) && !st_ff.pos[0];
  end

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb begin
    nxt_st = st_ff;

    // Three-stage synchroniser; a change counts once stages two and three agree
    nxt_st.sync1 = pins;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    nxt_st.filt = (st_ff.filt & (st_ff.sync2 ^ st_ff.sync3)) |
                  (st_ff.sync2 & ~(st_ff.sync2 ^ st_ff.sync3));

    // Flash slot prescaler and pulse-group position
    if (st_ff.slot_cnt == SLOT_LAST) begin
      nxt_st.slot_cnt = 32'h0;
      nxt_st.pos = (st_ff.pos + 5'h01 >= group_len) ? 5'h00 : st_ff.pos + 5'h01;
    end else begin
      nxt_st.slot_cnt = st_ff.slot_cnt + 32'h1;
    end
    if (st_ff.yel_cnt == YEL_LAST) begin
      nxt_st.yel_cnt = 32'h0;
      nxt_st.yel_ph = !st_ff.yel_ph;
    end else begin
      nxt_st.yel_cnt = st_ff.yel_cnt + 32'h1;
    end

    // Failure handling
    unique case (st_ff.state)
      gldc_pkg::ST_RUN: begin
        nxt_st.warn_cnt = '0;
        if (imm_code != gldc_pkg::CODE_NONE) begin
          nxt_st.state = gldc_pkg::ST_FAIL;
          nxt_st.code = imm_code;
          nxt_st.seen_open = 1'b0;
        end else if (warn_code != gldc_pkg::CODE_NONE) begin
          nxt_st.state = gldc_pkg::ST_WARN;
          nxt_st.code = warn_code;
        end
      end
      gldc_pkg::ST_WARN: begin
        if (imm_code != gldc_pkg::CODE_NONE) begin
          nxt_st.state = gldc_pkg::ST_FAIL;
          nxt_st.code = imm_code;
          nxt_st.seen_open = 1'b0;
        end else if (warn_code == gldc_pkg::CODE_NONE) begin
          nxt_st.state = gldc_pkg::ST_RUN;
          nxt_st.code = gldc_pkg::CODE_NONE;
        end else if (st_ff.warn_cnt == WARN_LAST) begin
          nxt_st.state = gldc_pkg::ST_FAIL;
          nxt_st.code = warn_code;
          nxt_st.seen_open = 1'b0;
        end else begin
          nxt_st.code = warn_code;
          nxt_st.warn_cnt = st_ff.warn_cnt + 1'b1;
        end
      end
      gldc_pkg::ST_FAIL: begin
        nxt_st.warn_cnt = '0;
        if (!p.guard_closed) begin
          nxt_st.seen_open = 1'b1;
        end
        if (st_ff.seen_open && p.guard_closed && locked &&
            imm_code == gldc_pkg::CODE_NONE && warn_code == gldc_pkg::CODE_NONE) begin
          nxt_st.state = gldc_pkg::ST_RUN;
          nxt_st.code = gldc_pkg::CODE_NONE;
          nxt_st.seen_open = 1'b0;
        end
      end
    endcase

    // Outputs, taken from the state being entered
    nxt_st.outs.safe_out_a = (p.act_detect | p.guard_closed) &&
                             nxt_st.state != gldc_pkg::ST_FAIL;
    nxt_st.outs.safe_out_b = nxt_st.outs.safe_out_a;
    nxt_st.outs.lock_path_out = (nxt_st.state == gldc_pkg::ST_FAIL) | locked;
    nxt_st.outs.lock_path_out_n = !nxt_st.outs.lock_path_out;
    nxt_st.outs.diag_out = p.guard_closed && p.act_detect &&
                           nxt_st.state == gldc_pkg::ST_RUN;
    if (nxt_st.state == gldc_pkg::ST_FAIL || !p.guard_closed) begin
      nxt_st.outs.led_yellow = 1'b0;
    end else if (locked && !p.act_near) begin
      nxt_st.outs.led_yellow = 1'b1;
    end else begin
      nxt_st.outs.led_yellow = st_ff.yel_ph;
    end
    if (nxt_st.code == gldc_pkg::CODE_INTERNAL) begin
      nxt_st.outs.led_red = 1'b1;
    end else if (nxt_st.code != gldc_pkg::CODE_NONE) begin
      nxt_st.outs.led_red = red_flash;
    end else begin
      nxt_st.outs.led_red = 1'b0;
    end
    nxt_st.outs.led_green = p.ready;
    if (st_ff.ctrl[gldc_pkg::CTRL_LAMP_BIT]) begin
      nxt_st.outs.led_green = 1'b1;
      nxt_st.outs.led_yellow = 1'b1;
      nxt_st.outs.led_red = 1'b1;
    end

    // AXI4-Lite write: address and data in either order, then response
    if (s_axi_awvalid && st_ff.awready) begin
      nxt_st.aw_got = 1'b1;
      nxt_st.awaddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && st_ff.wready) begin
      nxt_st.w_got = 1'b1;
      nxt_st.wdata = s_axi_wdata;
      nxt_st.wstrb = s_axi_wstrb;
    end
    if (st_ff.bvalid && s_axi_bready) begin
      nxt_st.bvalid = 1'b0;
    end
    if (st_ff.aw_got && st_ff.w_got && !st_ff.bvalid) begin
      nxt_st.aw_got = 1'b0;
      nxt_st.w_got = 1'b0;
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp = gldc_pkg::RESP_OKAY;
      if (st_ff.awaddr[7:2] == gldc_pkg::ADDR_CTRL[7:2]) begin
        for (int i = 0; i < 4; i++) begin
          if (st_ff.wstrb[i]) begin
            nxt_st.ctrl[i*8 +: 8] = st_ff.wdata[i*8 +: 8];
          end
        end
      end else if (st_ff.awaddr[7:2] != gldc_pkg::ADDR_STATUS[7:2]) begin
        nxt_st.bresp = gldc_pkg::RESP_SLVERR;
      end
    end
    nxt_st.awready = !nxt_st.aw_got && !nxt_st.bvalid;
    nxt_st.wready = !nxt_st.w_got && !nxt_st.bvalid;

    // AXI4-Lite read
    if (st_ff.rvalid && s_axi_rready) begin
      nxt_st.rvalid = 1'b0;
    end
    if (s_axi_arvalid && st_ff.arready) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp = gldc_pkg::RESP_OKAY;
      nxt_st.rdata = 32'h0;
      if (s_axi_araddr[7:2] == gldc_pkg::ADDR_CTRL[7:2]) begin
        nxt_st.rdata = st_ff.ctrl;
      end else if (s_axi_araddr[7:2] == gldc_pkg::ADDR_STATUS[7:2]) begin
        nxt_st.rdata[gldc_pkg::STS_STATE_LSB +: 3] = st_ff.state;
        nxt_st.rdata[gldc_pkg::STS_CODE_LSB +: 3] = st_ff.code;
        nxt_st.rdata[gldc_pkg::STS_SAFE_BIT] = st_ff.outs.safe_out_a;
        nxt_st.rdata[gldc_pkg::STS_LOCK_BIT] = st_ff.outs.lock_path_out;
        nxt_st.rdata[gldc_pkg::STS_DIAG_BIT] = st_ff.outs.diag_out;
        nxt_st.rdata[gldc_pkg::STS_OPEN_BIT] = st_ff.seen_open;
      end else begin
        nxt_st.rresp = gldc_pkg::RESP_SLVERR;
      end
    end
    nxt_st.arready = !nxt_st.rvalid;
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff <= '0;
      st_ff.state <= gldc_pkg::ST_RUN;
      st_ff.ctrl <= gldc_pkg::CTRL_RST;
      st_ff.outs.lock_path_out_n <= 1'b1;
      st_ff.awready <= 1'b1;
      st_ff.wready <= 1'b1;
      st_ff.arready <= 1'b1;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign outs = st_ff.outs;
  assign s_axi_awready = st_ff.awready;
  assign s_axi_wready = st_ff.wready;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp = st_ff.bresp;
  assign s_axi_arready = st_ff.arready;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rdata = st_ff.rdata;
  assign s_axi_rresp = st_ff.rresp;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_fail_drops_safe: assert property (
    st_ff.state == gldc_pkg::ST_FAIL |-> !outs.safe_out_a && !outs.safe_out_b && outs.lock_path_out
  ) else $error("safety outputs high in failure");

  a_imm_to_fail: assert property (
    st_ff.state == gldc_pkg::ST_RUN && p.err_internal |=>
      st_ff.state == gldc_pkg::ST_FAIL && st_ff.code == gldc_pkg::CODE_INTERNAL ##0 outs.led_red
  ) else $error("internal error did not latch failure");

  a_lock_three: assert property (
    outs.lock_path_out && st_ff.state != gldc_pkg::ST_FAIL |-> $past(locked)
  ) else $error("second path enabled without full lock");

  a_path_compl: assert property (
    outs.lock_path_out != outs.lock_path_out_n
  ) else $error("second path and complement agree");

  a_warn_locked: assert property (
    st_ff.state == gldc_pkg::ST_WARN && $past(locked) |->
      outs.safe_out_a && outs.lock_path_out && !outs.diag_out
  ) else $error("warning outputs wrong while locked");

  a_warn_clears: assert property (
    st_ff.state == gldc_pkg::ST_WARN && warn_code == gldc_pkg::CODE_NONE &&
    imm_code == gldc_pkg::CODE_NONE |=> st_ff.state == gldc_pkg::ST_RUN
  ) else $error("warning did not clear itself");

  a_fail_holds: assert property (
    st_ff.state == gldc_pkg::ST_FAIL && !st_ff.seen_open |=> st_ff.state == gldc_pkg::ST_FAIL
  ) else $error("failure left without guard cycling");

  a_restart_locked: assert property (
    $past(st_ff.state) == gldc_pkg::ST_FAIL && st_ff.state == gldc_pkg::ST_RUN |->
      $past(locked) && $past(st_ff.seen_open)
  ) else $error("restart while not locked");

  a_warn_timeout: assert property (
    st_ff.state == gldc_pkg::ST_WARN && st_ff.warn_cnt == WARN_LAST &&
    warn_code != gldc_pkg::CODE_NONE && imm_code == gldc_pkg::CODE_NONE |=>
      st_ff.state == gldc_pkg::ST_FAIL ##1 !outs.safe_out_a
  ) else $error("warning delay did not end in failure");

  a_green_ready: assert property (
    outs.led_green == $past(p.ready | st_ff.ctrl[gldc_pkg::CTRL_LAMP_BIT])
  ) else $error("green indicator not following readiness");

  a_bresp_hold: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp)
  ) else $error("write response dropped before taken");

  c_enter_fail: cover property (
    st_ff.state == gldc_pkg::ST_RUN ##1 st_ff.state == gldc_pkg::ST_FAIL);
  c_warn_recover: cover property (
    st_ff.state == gldc_pkg::ST_WARN ##1 st_ff.state == gldc_pkg::ST_RUN);
  c_fail_restart: cover property (
    st_ff.state == gldc_pkg::ST_FAIL ##1 st_ff.state == gldc_pkg::ST_RUN);
  c_red_pulse: cover property (
    st_ff.code == gldc_pkg::CODE_CROSS && $rose(outs.led_red));

endmodule // gldc_top

// file: test/gldc_plc_model.sv
/*
 * Behavioural model of the machine safety controller that reads the
 * enabling paths and drives the solenoid command line.
 * Assumes gldc_pkg is compiled first and the outputs share aclk.
 */
`timescale 1ns/1ps

module gldc_plc_model #(
  parameter bit POWER_TO_LOCK = 1'b0
) (
  // Clock
  input wire logic aclk,
  // Observed device outputs
  input wire gldc_pkg::gldc_outs_s outs,
  // Machine side
  input wire logic want_lock,
  output logic run_permit_ff,
  output logic sol_cmd
);
  // ---------------------------------------------------------------
  // Solenoid command and run permission
  // ---------------------------------------------------------------
  // High releases the lock in one variant and engages it in the other
  assign sol_cmd = POWER_TO_LOCK ? want_lock : !want_lock;

  // Run only with both paths up and the complement low
  always_ff @(posedge aclk) begin
    run_permit_ff <= outs.safe_out_a & outs.safe_out_b & outs.lock_path_out
                     & !outs.lock_path_out_n;
  end
endmodule // gldc_plc_model

// file: test/gldc_top_tb.sv
/*
 * Self-checking bench of the guard-lock diagnostic controller: pin states,
 * flash codes, warning timer, failure latch and register bus.
 * Assumes gldc_pkg, gldc_top and gldc_plc_model are compiled first.
 */
`timescale 1ns/1ps

module gldc_top_tb;
  localparam int WARN = 200;
  localparam int SLOT = 4;
  localparam int YHALF = 3;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  gldc_pkg::gldc_pins_s pins = '0;
  gldc_pkg::gldc_outs_s outs;
  logic [7:0] awa = 8'h00;
  logic [7:0] ara = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] ws = 4'hf;
  logic awv = 1'b0;
  logic wv = 1'b0;
  logic bry = 1'b0;
  logic arv = 1'b0;
  logic rry = 1'b0;
  logic awr, wrd, bv, arr, rv, permit, sol;
  logic [1:0] br, rr;
  logic [31:0] rd;
  int errors = 0;
  int cmp_count = 0;

  always #4 aclk = ~aclk;

  gldc_top #(.WARN_CYC(WARN), .SLOT_CYC(SLOT), .YEL_HALF(YHALF)) i_dut (
    .aclk(aclk), .aresetn(aresetn), .pins(pins), .outs(outs),
    .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
    .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrd),
    .s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry),
    .s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arr),
    .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry)
  );

  gldc_plc_model i_plc (
    .aclk(aclk), .outs(outs), .want_lock(1'b1), .run_permit_ff(permit), .sol_cmd(sol)
  );

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic test_done();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic chk_o(input logic [7:0] m, input logic [7:0] e);
    chk({24'h0, outs & m}, {24'h0, e & m});
  endtask

  // One write or one read; valid held until its own handshake edge
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic [1:0] r);
    int n;
    logic done, aw_hs, w_hs, ar_hs;
    n = 0;
    done = 1'b0;
    @(posedge aclk);
    if (wr) begin
      awa <= a;
      wd <= d;
      awv <= 1'b1;
      wv <= 1'b1;
      bry <= 1'b1;
    end else begin
      ara <= a;
      arv <= 1'b1;
      rry <= 1'b1;
    end
    while (!done && n < 50) begin
      @(negedge aclk);
      n++;
      aw_hs = awv & awr;
      w_hs = wv & wrd;
      ar_hs = arv & arr;
      done = wr ? (bv & bry) : (rv & rry);
      q = rd;
      r = wr ? br : rr;
      @(posedge aclk);
      if (aw_hs) awv <= 1'b0;
      if (w_hs) wv <= 1'b0;
      if (ar_hs) arv <= 1'b0;
    end
    bry <= 1'b0;
    rry <= 1'b0;
    if (!done) begin
      errors++;
      test_done();
    end
  endtask

  // Apply pins and let sync, filter and output register settle
  task automatic setp(input logic [12:0] v);
    @(posedge aclk);
    pins <= v;
    repeat (8) @(posedge aclk);
    @(negedge aclk);
  endtask

  task automatic watch(input int cyc, input int b, output int hi, output int rise);
    logic prev;
    hi = 0;
    rise = 0;
    @(negedge aclk);
    prev = outs[b];
    repeat (cyc) begin
      @(negedge aclk);
      hi += outs[b];
      rise += (outs[b] & !prev);
      prev = outs[b];
    end
  endtask

  task automatic recover();
    setp(13'h1000);
    chk_o(8'hfe, 8'h24);
    setp(13'h1d00);
    chk_o(8'hfe, 8'h24);
    setp(13'h1d80);
    chk_o(8'hff, 8'hee);
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_regs();
    logic [31:0] q;
    logic [1:0] r;
    bus(1'b0, gldc_pkg::ADDR_CTRL, 32'h0, q, r);
    chk(q, gldc_pkg::CTRL_RST);
    bus(1'b1, gldc_pkg::ADDR_CTRL, 32'h1, q, r);
    chk(32'(r), 32'(gldc_pkg::RESP_OKAY));
    repeat (3) @(negedge aclk);
    chk_o(8'h07, 8'h07);
    bus(1'b0, gldc_pkg::ADDR_CTRL, 32'h0, q, r);
    chk(q, 32'h1);
    bus(1'b1, gldc_pkg::ADDR_CTRL, 32'h0, q, r);
    // Only byte lane one is enabled: lamp bit must stay clear
    ws <= 4'h2;
    bus(1'b1, gldc_pkg::ADDR_CTRL, 32'h0000_0301, q, r);
    ws <= 4'hf;
    bus(1'b0, gldc_pkg::ADDR_CTRL, 32'h0, q, r);
    chk(q, 32'h0000_0300);
    bus(1'b1, gldc_pkg::ADDR_STATUS, 32'hffff_ffff, q, r);
    chk(32'(r), 32'(gldc_pkg::RESP_OKAY));
    bus(1'b0, gldc_pkg::ADDR_STATUS, 32'h0, q, r);
    chk(q & 32'h7, 32'h1);
    bus(1'b1, 8'h08, 32'h1, q, r);
    chk(32'(r), 32'(gldc_pkg::RESP_SLVERR));
    bus(1'b0, 8'h08, 32'h0, q, r);
    chk({q[29:0], r}, {30'h0, gldc_pkg::RESP_SLVERR});
    repeat (3) @(negedge aclk);
    chk_o(8'hff, 8'h14);
  endtask

  task automatic t_states();
    int hi, ri;
    setp(13'h1800);
    chk_o(8'hfd, 8'hd4);
    watch(4 * YHALF, 1, hi, ri);
    chk(hi, 2 * YHALF);
    setp(13'h1c00);
    chk_o(8'hfd, 8'hdc);
    watch(4 * YHALF, 1, hi, ri);
    chk(hi, 2 * YHALF);
    setp(13'h1c80);
    chk_o(8'h30, 8'h10);
    setp(13'h1d80);
    chk_o(8'hff, 8'hee);
    chk(32'(permit), 32'h1);
    chk(32'(sol), 32'h0);
    setp(13'h1f80);
    watch(4 * YHALF, 1, hi, ri);
    chk(hi, 2 * YHALF);
  endtask

  task automatic t_warn();
    logic [31:0] q;
    logic [1:0] r;
    int hi, ri;
    for (int c = 1; c <= 4; c++) begin
      setp(13'h1d80 | (13'h0040 >> (c - 1)));
      chk_o(8'hfe, 8'he6);
      watch((2 * c + 4) * SLOT, 0, hi, ri);
      chk(ri, c);
      bus(1'b0, gldc_pkg::ADDR_STATUS, 32'h0, q, r);
      chk(q & 32'h77, c * 16 + 2);
      setp(13'h1d80);
      chk_o(8'hff, 8'hee);
    end
  endtask

  task automatic t_expire();
    setp(13'h1d90);
    repeat (WARN - 60) @(negedge aclk);
    chk_o(8'hfe, 8'he6);
    repeat (70) @(negedge aclk);
    chk_o(8'hfe, 8'h24);
    setp(13'h1d80);
    chk_o(8'hfe, 8'h24);
    recover();
  endtask

  task automatic t_immed();
    int hi, ri;
    for (int c = 5; c <= 7; c++) begin
      setp(13'h1d80 | (13'h0004 >> (c - 5)));
      chk_o(8'hfe, 8'h24);
      watch((2 * c + 4) * SLOT, 0, hi, ri);
      if (c == 7) chk(hi, (2 * c + 4) * SLOT);
      else chk(ri, c);
      setp(13'h1d80);
      chk_o(8'hfe, 8'h24);
      recover();
    end
  endtask

  // ---------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------
  initial begin
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    setp(13'h1000);
    t_regs();
    t_states();
    t_warn();
    t_expire();
    t_immed();
    test_done();
  end
endmodule // gldc_top_tb
